// ===== src/setc_sensor.sv
// sensor end: link register slave, frame timing and exposure re-timing
// assumes the controller offers bytes one at a time and waits for ack
//
// Operation
// - divide select decodes to ratio one to sixteen
// - pixel period is two times ratio clocks
// - frame length defaults 524, raisable to 1023
// - line length defaults 762, raisable to 1023
// - controller keeps coarse within frame length minus two
// - controller keeps fine between eleven and line
// - integration equals coarse times line plus fine
// - software computes exposure and gain; controller only clamps exposure
// - controller writes exposure and gain in one burst
// - new values shadowed, applied at frame start
// - pending flag high until exposure reaches array
// - gain applied one frame after exposure
// - no transfer while exposure page being written
// - undivided pixel rate is half input clock
// - index msb set enables index auto increment
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module setc_sensor
	import setc_pkg::*;
(
	input wire logic CLK_IN, // 250 mhz clock
	input wire logic RSTN_IN, // async reset, low
	setc_link_if.sensor link, // byte link from controller
	output logic PIXEL_TICK_OUT, // one pulse per pixel period
	output logic [PER_W-1:0] PIXEL_PERIOD_OUT, // period in clocks
	output logic FRAME_START_OUT, // pulse at frame start
	output logic [LEN_W-1:0] COL_OUT, // pixel within line
	output logic [LEN_W-1:0] LINE_OUT, // line within frame
	output logic [LEN_W-1:0] COARSE_OUT, // applied coarse
	output logic [LEN_W-1:0] FINE_OUT, // applied fine
	output logic [GAIN_W-1:0] GAIN_OUT, // applied gain
	output logic [INTEG_W-1:0] INTEG_PIXELS_OUT, // integration periods
	output logic EXP_PENDING_OUT // exposure written, not applied
);
	logic [6:0] index;
	logic auto_inc;
	logic first_byte;
	logic accept;
	logic wr;
	logic wr_exp_page;
	logic wr_exp;
	logic wr_gain;
	logic writing_exp;
	logic [DIV_SEL_W-1:0] clk_div;
	logic [LEN_W-1:0] frame_reg;
	logic [LEN_W-1:0] line_reg;
	logic [LEN_W-1:0] frame_eff;
	logic [LEN_W-1:0] line_eff;
	logic [LEN_W-1:0] fine_sh;
	logic [LEN_W-1:0] coarse_sh;
	logic [GAIN_W-1:0] gain_sh;
	logic [GAIN_W-1:0] gain_stage;
	logic gain_stage_vld;
	logic exp_dirty;
	logic gain_dirty;
	logic pix_tick;
	logic [PER_W-1:0] period;
	logic transfer;
	logic next_exp_dirty;

	// ------------------------------------------------------------------
	// byte acceptance
	// ------------------------------------------------------------------
	// ack is registered, so a held byte is taken once only
	assign accept = link.sel && link.byte_valid && !link.byte_ack;
	assign wr = accept && !first_byte;
	assign wr_exp_page = wr && (index[6:4] == EXP_PAGE);
	assign wr_exp = wr && (index == IDX_FINE_H || index == IDX_FINE_L ||
		index == IDX_COARSE_H || index == IDX_COARSE_L);
	assign wr_gain = wr && (index == IDX_GAIN);

	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			link.byte_ack <= 1'b0;
		end else begin
			link.byte_ack <= accept;
		end
	end

	// first byte after a message opens is the index byte
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			first_byte <= 1'b1;
		end else if (!link.sel) begin
			first_byte <= 1'b1;
		end else if (accept) begin
			first_byte <= 1'b0;
		end
	end

	// index kept across messages; steps after each acked data byte when auto increment is set
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			index <= 7'h00;
			auto_inc <= 1'b0;
		end else if (accept && first_byte) begin
			index <= link.byte_data[6:0];
			auto_inc <= link.byte_data[INC_BIT];
		end else if (wr && auto_inc) begin
			index <= index + 7'h01;
		end
	end

	// ------------------------------------------------------------------
	// geometry and shadow registers
	// ------------------------------------------------------------------
	// exposure and gain land in shadow copies only
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			clk_div <= CLK_DIV_DEF;
			frame_reg <= FRAME_LEN_DEF;
			line_reg <= LINE_LEN_DEF;
			fine_sh <= LINE_LEN_DEF;
			coarse_sh <= FRAME_LEN_DEF - COARSE_MARGIN;
			gain_sh <= GAIN_DEF;
		end else if (wr) begin
			unique case (index)
				IDX_CLK_DIV: clk_div <= link.byte_data[3:0];
				IDX_LINE_H: line_reg[9:8] <= link.byte_data[1:0];
				IDX_LINE_L: line_reg[7:0] <= link.byte_data;
				IDX_FRAME_H: frame_reg[9:8] <= link.byte_data[1:0];
				IDX_FRAME_L: frame_reg[7:0] <= link.byte_data;
				IDX_FINE_H: fine_sh[9:8] <= link.byte_data[1:0];
				IDX_FINE_L: fine_sh[7:0] <= link.byte_data;
				IDX_COARSE_H: coarse_sh[9:8] <= link.byte_data[1:0];
				IDX_COARSE_L: coarse_sh[7:0] <= link.byte_data;
				IDX_GAIN: gain_sh <= link.byte_data;
				default: ; // unused locations ignore writes
			endcase
		end
	end

	// lengths can only be raised above their defaults
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			frame_eff <= FRAME_LEN_DEF;
			line_eff <= LINE_LEN_DEF;
		end else begin
			frame_eff <= (frame_reg < FRAME_LEN_DEF) ? FRAME_LEN_DEF :
				frame_reg;
			line_eff <= (line_reg < LINE_LEN_DEF) ? LINE_LEN_DEF :
				line_reg;
		end
	end

	// ------------------------------------------------------------------
	// pixel, line and frame timing
	// ------------------------------------------------------------------
	setc_pixdiv setc_pixdiv_i (
		.clk_in(CLK_IN),
		.rstn_in(RSTN_IN),
		.div_sel_in(clk_div),
		.tick_out(pix_tick),
		.period_out(period)
	);

	// counters compare with >= so a shortened length never overruns
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			COL_OUT <= '0;
			LINE_OUT <= '0;
			FRAME_START_OUT <= 1'b0;
			PIXEL_TICK_OUT <= 1'b0;
			PIXEL_PERIOD_OUT <= 6'h02;
		end else begin
			PIXEL_TICK_OUT <= pix_tick;
			PIXEL_PERIOD_OUT <= period;
			FRAME_START_OUT <= 1'b0;
			if (pix_tick) begin
				if (COL_OUT >= line_eff - 10'h001) begin
					COL_OUT <= '0;
					if (LINE_OUT >= frame_eff - 10'h001) begin
						LINE_OUT <= '0;
						FRAME_START_OUT <= 1'b1;
					end else begin
						LINE_OUT <= LINE_OUT + 10'h001;
					end
				end else begin
					COL_OUT <= COL_OUT + 10'h001;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// exposure re-timing
	// ------------------------------------------------------------------
	// page writes in flight hold off the transfer until message ends
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			writing_exp <= 1'b0;
		end else if (!link.sel) begin
			writing_exp <= 1'b0;
		end else if (wr_exp_page) begin
			writing_exp <= 1'b1;
		end
	end

	// a deferred transfer waits for the next frame start
	assign transfer = FRAME_START_OUT && !writing_exp &&
		!wr_exp_page;

	// set beats clear so a write in the transfer cycle is kept
	always_comb begin
		next_exp_dirty = exp_dirty;
		if (transfer) begin
			next_exp_dirty = 1'b0;
		end
		if (wr_exp) begin
			next_exp_dirty = 1'b1;
		end
	end

	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			exp_dirty <= 1'b0;
			EXP_PENDING_OUT <= 1'b0;
			link.exp_pending <= 1'b0;
		end else begin
			exp_dirty <= next_exp_dirty;
			EXP_PENDING_OUT <= next_exp_dirty;
			link.exp_pending <= next_exp_dirty;
		end
	end

	// applied exposure changes only at a transferring frame start
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			COARSE_OUT <= FRAME_LEN_DEF - COARSE_MARGIN;
			FINE_OUT <= LINE_LEN_DEF;
		end else if (transfer && exp_dirty) begin
			COARSE_OUT <= coarse_sh;
			FINE_OUT <= fine_sh;
		end
	end

	// gain goes through a stage so it lands one frame later
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			gain_dirty <= 1'b0;
			gain_stage <= GAIN_DEF;
			gain_stage_vld <= 1'b0;
			GAIN_OUT <= GAIN_DEF;
		end else begin
			if (wr_gain) begin
				gain_dirty <= 1'b1;
			end else if (transfer) begin
				gain_dirty <= 1'b0;
			end
			if (FRAME_START_OUT && gain_stage_vld) begin
				GAIN_OUT <= gain_stage;
			end
			if (transfer && gain_dirty) begin
				gain_stage <= gain_sh;
				gain_stage_vld <= 1'b1;
			end else if (FRAME_START_OUT) begin
				gain_stage_vld <= 1'b0;
			end
		end
	end

	// integration in pixel periods, one cycle behind its inputs
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			INTEG_PIXELS_OUT <= '0;
		end else begin
			INTEG_PIXELS_OUT <= INTEG_W'(COARSE_OUT) * INTEG_W'(line_eff) +
				INTEG_W'(FINE_OUT);
		end
	end
endmodule

// ===== src/setc_pkg.sv
// shared constants, encodings and decode helpers for the exposure timing
// block and its controller; assumes both ends run on one common clock
package setc_pkg;

	// ------------------------------------------------------------------
	// sensor register indexes on the link
	// ------------------------------------------------------------------
	localparam logic [6:0] IDX_CLK_DIV = 7'h12;
	localparam logic [6:0] IDX_LINE_H = 7'h52;
	localparam logic [6:0] IDX_LINE_L = 7'h53;
	localparam logic [6:0] IDX_FRAME_H = 7'h61;
	localparam logic [6:0] IDX_FRAME_L = 7'h62;
	localparam logic [6:0] IDX_FINE_H = 7'h20;
	localparam logic [6:0] IDX_FINE_L = 7'h21;
	localparam logic [6:0] IDX_COARSE_H = 7'h22;
	localparam logic [6:0] IDX_COARSE_L = 7'h23;
	localparam logic [6:0] IDX_GAIN = 7'h24;
	localparam logic [2:0] EXP_PAGE = 3'h2; // index[6:4] of exposure page
	localparam int INC_BIT = 7; // auto increment flag in index byte

	// ------------------------------------------------------------------
	// widths, defaults and limits
	// ------------------------------------------------------------------
	localparam int LEN_W = 10;
	localparam int GAIN_W = 8;
	localparam int DIV_SEL_W = 4;
	localparam int INTEG_W = 21;
	localparam int PER_W = 6;
	localparam logic [9:0] FRAME_LEN_DEF = 10'h20c;
	localparam logic [9:0] LINE_LEN_DEF = 10'h2fa;
	localparam logic [9:0] FINE_MIN = 10'h00b;
	localparam logic [9:0] COARSE_MARGIN = 10'h002;
	localparam logic [3:0] CLK_DIV_DEF = 4'h0;
	localparam logic [7:0] GAIN_DEF = 8'h00;

	// ------------------------------------------------------------------
	// controller register map (byte addresses on apb)
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_COARSE = 8'h08;
	localparam logic [7:0] ADDR_FINE = 8'h0c;
	localparam logic [7:0] ADDR_GAIN = 8'h10;
	localparam logic [7:0] ADDR_FRAME = 8'h14;
	localparam logic [7:0] ADDR_LINE = 8'h18;
	localparam logic [7:0] ADDR_SINGLE = 8'h1c;
	localparam int CMD_EXP_BIT = 0;
	localparam int CMD_SINGLE_BIT = 1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_PEND_BIT = 1;
	localparam int SINGLE_IDX_LSB = 8;
	localparam int MSG_MAX = 6;
	localparam logic [2:0] MSG_EXP_LEN = 3'h6;
	localparam logic [2:0] MSG_SINGLE_LEN = 3'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SEND = 3'b010,
		ST_GAP = 3'b100
	} setc_state_t;

	// divide select to ratio n
	function automatic logic [4:0] setc_div_ratio(input logic [3:0] sel);
		if (sel == 4'h0) begin
			return 5'h01;
		end else if (sel == 4'h1) begin
			return 5'h02;
		end else begin
			// 001x is 4 up to 111x is 16: two per step above 2
			return {1'b0, sel[3:1], 1'b0} + 5'h02;
		end
	endfunction

endpackage

// ===== src/setc_link_if.sv
// byte link between controller and sensor timing block
// assumes both ends share one clock, so no crossing is needed
`timescale 1ns/1ps
interface setc_link_if;
	logic sel; // message in progress
	logic byte_valid; // byte offered
	logic [7:0] byte_data; // index or data byte
	logic byte_ack; // one-cycle acknowledge
	logic exp_pending; // written exposure not yet applied

	modport ctrl (
		output sel, byte_valid, byte_data,
		input byte_ack, exp_pending
	);
	modport sensor (
		input sel, byte_valid, byte_data,
		output byte_ack, exp_pending
	);
endinterface

// ===== src/setc_pixdiv.sv
// pixel rate divider: one tick every 2*n input clocks
// assumes div_sel_in comes from logic on the same clock
`timescale 1ns/1ps
module setc_pixdiv
	import setc_pkg::*;
(
	input wire logic clk_in, // input clock
	input wire logic rstn_in, // async reset, low
	input wire logic [DIV_SEL_W-1:0] div_sel_in, // divide select
	output logic tick_out, // pixel period pulse
	output logic [PER_W-1:0] period_out // period in clocks
);
	logic [PER_W-1:0] cnt;
	logic [PER_W-1:0] next_period;

	// ------------------------------------------------------------------
	// ratio decode
	// ------------------------------------------------------------------
	// pixel period is twice the ratio
	always_comb begin
		next_period = {setc_div_ratio(div_sel_in), 1'b0};
	end

	// ------------------------------------------------------------------
	// counter
	// ------------------------------------------------------------------
	// undivided: tick every 2 clocks, half the input rate
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt <= '0;
			tick_out <= 1'b0;
			period_out <= 6'h02;
		end else begin
			period_out <= next_period;
			if (cnt >= next_period - 6'h01) begin
				cnt <= '0;
				tick_out <= 1'b1;
			end else begin
				cnt <= cnt + 6'h01;
				tick_out <= 1'b0;
			end
		end
	end
endmodule

// ===== src/setc_ctrl.sv
// controller end: apb register slave that sends exposure and gain
// assumes the sensor end acks every byte on the same clock
`timescale 1ns/1ps
module setc_ctrl
	import setc_pkg::*;
(
	input wire logic CLK_IN, // 250 mhz clock
	input wire logic RSTN_IN, // async reset, low
	input wire logic PSEL_IN, // apb select
	input wire logic PENABLE_IN, // apb enable
	input wire logic PWRITE_IN, // apb direction
	input wire logic [7:0] PADDR_IN, // apb byte address
	input wire logic [31:0] PWDATA_IN, // apb write data
	output logic [31:0] PRDATA_OUT, // apb read data
	output logic PREADY_OUT, // apb ready
	output logic PSLVERR_OUT, // apb error, unmapped address
	setc_link_if.ctrl link // byte link to sensor
);
	setc_state_t state;
	logic [LEN_W-1:0] coarse;
	logic [LEN_W-1:0] fine;
	logic [GAIN_W-1:0] gain;
	logic [LEN_W-1:0] frame_len;
	logic [LEN_W-1:0] line_len;
	logic [15:0] single;
	logic [7:0] msg [MSG_MAX];
	logic [2:0] msg_len;
	logic [2:0] cnt;
	logic apb_wr;
	logic setup;
	logic mapped;
	logic go_exp;
	logic go_single;
	logic [LEN_W-1:0] coarse_c;
	logic [LEN_W-1:0] fine_c;
	logic [LEN_W-1:0] coarse_max;

	// ------------------------------------------------------------------
	// apb slave, one wait-free access phase
	// ------------------------------------------------------------------
	assign setup = PSEL_IN && !PENABLE_IN;
	assign apb_wr = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT;
	assign mapped = (PADDR_IN[1:0] == 2'h0) && (PADDR_IN <= ADDR_SINGLE);
	assign go_exp = apb_wr && mapped && PADDR_IN == ADDR_CMD &&
		PWDATA_IN[CMD_EXP_BIT] && state == ST_IDLE;
	assign go_single = apb_wr && mapped && PADDR_IN == ADDR_CMD &&
		PWDATA_IN[CMD_SINGLE_BIT] && !PWDATA_IN[CMD_EXP_BIT] &&
		state == ST_IDLE;

	// ready and read data prepared in setup, shown in access
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			PREADY_OUT <= 1'b0;
			PSLVERR_OUT <= 1'b0;
			PRDATA_OUT <= 32'h00000000;
		end else begin
			PREADY_OUT <= setup;
			PSLVERR_OUT <= setup && !mapped;
			PRDATA_OUT <= 32'h00000000;
			if (setup && !PWRITE_IN && mapped) begin
				unique case (PADDR_IN)
					ADDR_STATUS: PRDATA_OUT <= {30'h0, link.exp_pending,
						state != ST_IDLE};
					ADDR_COARSE: PRDATA_OUT <= {22'h0, coarse};
					ADDR_FINE: PRDATA_OUT <= {22'h0, fine};
					ADDR_GAIN: PRDATA_OUT <= {24'h0, gain};
					ADDR_FRAME: PRDATA_OUT <= {22'h0, frame_len};
					ADDR_LINE: PRDATA_OUT <= {22'h0, line_len};
					ADDR_SINGLE: PRDATA_OUT <= {16'h0, single};
					default: PRDATA_OUT <= 32'h00000000;
				endcase
			end
		end
	end

	// software supplies the exposure and gain it has computed
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			coarse <= FRAME_LEN_DEF - COARSE_MARGIN;
			fine <= LINE_LEN_DEF;
			gain <= GAIN_DEF;
			frame_len <= FRAME_LEN_DEF;
			line_len <= LINE_LEN_DEF;
			single <= 16'h0000;
		end else if (apb_wr && mapped) begin
			unique case (PADDR_IN)
				ADDR_COARSE: coarse <= PWDATA_IN[9:0];
				ADDR_FINE: fine <= PWDATA_IN[9:0];
				ADDR_GAIN: gain <= PWDATA_IN[7:0];
				ADDR_FRAME: frame_len <= PWDATA_IN[9:0];
				ADDR_LINE: line_len <= PWDATA_IN[9:0];
				ADDR_SINGLE: single <= PWDATA_IN[15:0];
				default: ; // command and status hold no data
			endcase
		end
	end

	// ------------------------------------------------------------------
	// limits applied before sending
	// ------------------------------------------------------------------
	// clamps rely on frame and line copies matching the sensor
	always_comb begin
		coarse_max = (frame_len > COARSE_MARGIN) ?
			frame_len - COARSE_MARGIN : 10'h000;
		coarse_c = (coarse > coarse_max) ? coarse_max : coarse;
		fine_c = fine;
		if (fine < FINE_MIN) begin
			fine_c = FINE_MIN;
		end else if (fine > line_len) begin
			fine_c = line_len;
		end
	end

	// ------------------------------------------------------------------
	// message sequencer
	// ------------------------------------------------------------------
	// exposure burst is one auto-increment message
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			for (int i = 0; i < MSG_MAX; i++) begin
				msg[i] <= 8'h00;
			end
			msg_len <= 3'h0;
		end else if (go_exp) begin
			msg[0] <= {1'b1, IDX_FINE_H};
			msg[1] <= {6'h00, fine_c[9:8]};
			msg[2] <= fine_c[7:0];
			msg[3] <= {6'h00, coarse_c[9:8]};
			msg[4] <= coarse_c[7:0];
			msg[5] <= gain;
			msg_len <= MSG_EXP_LEN;
		end else if (go_single) begin
			msg[0] <= {1'b0, single[SINGLE_IDX_LSB +: 7]};
			msg[1] <= single[7:0];
			msg_len <= MSG_SINGLE_LEN;
		end
	end

	// one byte offered at a time, next one only after its ack
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			state <= ST_IDLE;
			cnt <= 3'h0;
			link.sel <= 1'b0;
			link.byte_valid <= 1'b0;
			link.byte_data <= 8'h00;
		end else begin
			unique case (state)
				ST_IDLE: begin
					cnt <= 3'h0;
					if (go_exp) begin
						link.sel <= 1'b1;
						link.byte_valid <= 1'b1;
						link.byte_data <= {1'b1, IDX_FINE_H};
						state <= ST_SEND;
					end else if (go_single) begin
						link.sel <= 1'b1;
						link.byte_valid <= 1'b1;
						link.byte_data <= {1'b0, single[SINGLE_IDX_LSB +: 7]};
						state <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (link.byte_ack) begin
						if (cnt == msg_len - 3'h1) begin
							link.sel <= 1'b0;
							link.byte_valid <= 1'b0;
							state <= ST_GAP;
						end else begin
							cnt <= cnt + 3'h1;
							link.byte_data <= msg[cnt + 3'h1];
						end
					end
				end
				ST_GAP: begin
					state <= ST_IDLE; // sel low one cycle ends message
				end
				default: begin
					state <= ST_IDLE;
					link.sel <= 1'b0;
					link.byte_valid <= 1'b0;
				end
			endcase
		end
	end
endmodule

// ===== verification/setc_link_sva.sv
// checker for the byte link between the controller and sensor ends
// assumes one shared clock and the async active low reset
`timescale 1ns/1ps
module setc_link_sva (
	input wire logic CLK_IN, // common clock
	input wire logic RSTN_IN, // async reset, low
	input wire logic sel, // message in progress
	input wire logic byte_valid, // byte offered
	input wire logic [7:0] byte_data, // link byte
	input wire logic byte_ack, // acknowledge pulse
	input wire logic exp_pending // exposure not applied
);
	// ----------------------------------------
	// link handshake and framing
	// ----------------------------------------
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RSTN_IN);
	// byte offered and not yet answered
	sequence s_offer;
		sel && byte_valid && !byte_ack;
	endsequence
	// one ack cycle, then quiet again
	sequence s_answer;
		byte_ack ##1 !byte_ack;
	endsequence
	AST_ACK_NEXT: assert property (s_offer |=> s_answer)
		else $error("byte not acked in one cycle");
	AST_ACK_CAUSE: assert property (byte_ack |-> $past(byte_valid))
		else $error("ack without an offered byte");
	AST_HOLD: assert property (s_offer |=> byte_valid && $stable(byte_data))
		else $error("byte changed before its ack");
	AST_ACK_SEL: assert property (byte_ack |-> sel)
		else $error("ack outside a message");
	AST_START: assert property ($rose(sel) |-> byte_valid)
		else $error("message opened without a byte");
	AST_END: assert property ($fell(sel) |-> !byte_valid && !byte_ack)
		else $error("message closed with a byte live");
	AST_GAP: assert property ($fell(sel) |=> !sel)
		else $error("no idle cycle between messages");
	// pending can only rise as a written byte is acked
	AST_PEND_RISE: assert property ($rose(exp_pending) |-> byte_ack)
		else $error("pending rose without a written byte");
endmodule

// ===== verification/setc_bench.sv
// bench: both ends joined by the link, controller driven over apb
// assumes 250 mhz clock; a frame is far longer than the run, so no
// frame start is reached and written exposure must stay pending
`timescale 1ns/1ps
module setc_bench
	import setc_pkg::*;
;
	logic clk = 1'b0;
	logic rstn, psel, pen, pwr, pready, pslverr, tick, pend, err, fs;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [PER_W-1:0] period;
	logic [LEN_W-1:0] coarse, fine, col, line;
	logic [GAIN_W-1:0] gain;
	logic [INTEG_W-1:0] integ;
	logic [7:0] seen[$];
	logic [31:0] rst_tab[5] = '{32'h20a, 32'h2fa, 32'h0, 32'h20c, 32'h2fa};
	int bad_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	setc_link_if setc_link_if_i ();
	setc_ctrl setc_ctrl_i (.CLK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
		.PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(pslverr), .link(setc_link_if_i.ctrl));
	setc_sensor setc_sensor_i (.CLK_IN(clk), .RSTN_IN(rstn),
		.link(setc_link_if_i.sensor), .PIXEL_TICK_OUT(tick),
		.PIXEL_PERIOD_OUT(period), .FRAME_START_OUT(fs), .COL_OUT(col),
		.LINE_OUT(line), .COARSE_OUT(coarse), .FINE_OUT(fine),
		.GAIN_OUT(gain), .INTEG_PIXELS_OUT(integ), .EXP_PENDING_OUT(pend));
	setc_link_sva setc_link_sva_i (.CLK_IN(clk), .RSTN_IN(rstn),
		.sel(setc_link_if_i.sel), .byte_valid(setc_link_if_i.byte_valid),
		.byte_data(setc_link_if_i.byte_data),
		.byte_ack(setc_link_if_i.byte_ack),
		.exp_pending(setc_link_if_i.exp_pending));
	// ----------------------------------------
	// clock, timeout and link monitor
	// ----------------------------------------
	always #2 clk = ~clk;
	// whole run needs well under two thousand cycles; a hang ends here
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			$display("BAD %0t run timed out", $time);
			final_report();
		end
	end
	// bytes as the sensor acks them, in wire order
	always @(posedge clk) begin
		if (setc_link_if_i.byte_ack === 1'b1) begin
			seen.push_back(setc_link_if_i.byte_data);
		end
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t %s: got %h want %h", $time, what, got, exp);
		end
	endtask
	// one apb transfer, entered just after an edge
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wait_idle();
		do apb(1'b0, ADDR_STATUS, 32'h0);
		while (rd[STAT_BUSY_BIT] !== 1'b0);
	endtask
	// send exposure; ce/fe are the values expected on the wire
	task automatic burst(input logic [9:0] c, input logic [9:0] f,
		input logic [7:0] g, input logic [9:0] ce, input logic [9:0] fe);
		logic [7:0] want[6];
		want = '{{1'b1, IDX_FINE_H}, {6'h0, fe[9:8]}, fe[7:0],
			{6'h0, ce[9:8]}, ce[7:0], g};
		seen.delete();
		apb(1'b1, ADDR_COARSE, {22'h0, c});
		apb(1'b1, ADDR_FINE, {22'h0, f});
		apb(1'b1, ADDR_GAIN, {24'h0, g});
		apb(1'b1, ADDR_CMD, 32'h1);
		// second order while busy must be dropped
		apb(1'b1, ADDR_CMD, 32'h1);
		wait_idle();
		chk(32'(seen.size()), 32'h6, "burst length");
		for (int i = 0; i < 6; i++) begin
			chk({24'h0, seen[i]}, {24'h0, want[i]}, "burst byte");
		end
	endtask
	task automatic done(input string name);
		$display("test %s finished", name);
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		int n;
		int gap;
		logic [LEN_W-1:0] c0, l0;
		logic [19:0] exp_pos;
		rstn = 1'b0;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, ADDR_COARSE + 8'(4 * i), 32'h0);
			chk(rd, rst_tab[i], "register reset");
		end
		chk({22'h0, coarse}, 32'h20a, "applied coarse");
		chk({22'h0, fine}, 32'h2fa, "applied fine");
		chk({11'h0, integ}, 32'h20a * 32'h2fa + 32'h2fa, "integ");
		chk({26'h0, period}, 32'h2, "undivided period");
		done("reset");
		// unmapped read and unaligned write are refused
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped error");
		chk(rd, 32'h0, "unmapped data");
		apb(1'b1, 8'h0e, 32'h3ff);
		chk({31'h0, err}, 32'h1, "unaligned error");
		apb(1'b0, ADDR_FINE, 32'h0);
		chk(rd, 32'h2fa, "fine untouched");
		done("unmapped");
		// every divide select; measure tick spacing after it settles
		for (int s = 0; s < 16; s++) begin
			n = (s == 0) ? 1 : (s == 1) ? 2 : 2 * (s / 2) + 2;
			apb(1'b1, ADDR_SINGLE, {17'h0, IDX_CLK_DIV, 8'(s)});
			apb(1'b1, ADDR_CMD, 32'h2);
			wait_idle();
			repeat (2) begin
				@(posedge clk);
				while (tick !== 1'b1) @(posedge clk);
			end
			// position seen at one tick must step by one at the next
			c0 = col;
			l0 = line;
			gap = 0;
			do begin
				@(posedge clk);
				gap++;
			end while (tick !== 1'b1);
			chk(32'(gap), 32'(2 * n), "tick spacing");
			exp_pos = (c0 == LINE_LEN_DEF - 10'h001) ?
				{l0 + 10'h001, 10'h000} : {l0, c0 + 10'h001};
			chk({12'h0, line, col}, {12'h0, exp_pos}, "pixel step");
			chk({31'h0, fs}, 32'h0, "no frame start yet");
			chk({26'h0, period}, 32'(2 * n), "pixel period");
		end
		done("divider");
		burst(10'h1f4, 10'h12c, 8'h5a, 10'h1f4, 10'h12c);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk({31'h0, rd[STAT_PEND_BIT]}, 32'h1, "status pending");
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, ADDR_FRAME + 8'(4 * i), 32'h3ff);
			apb(1'b0, ADDR_FRAME + 8'(4 * i), 32'h0);
			chk(rd, 32'h3ff, "length raised");
		end
		burst(10'h3ff, 10'h005, 8'ha5, 10'h3ff - COARSE_MARGIN, FINE_MIN);
		burst(10'h000, 10'h3ff, 8'h00, 10'h000, 10'h3ff);
		// no frame start yet, so nothing reaches the array
		chk({31'h0, pend}, 32'h1, "pending output");
		chk({22'h0, coarse}, 32'h20a, "coarse held");
		chk({22'h0, fine}, 32'h2fa, "fine held");
		chk({24'h0, gain}, 32'h0, "gain held");
		done("exposure");
		final_report();
	end
endmodule
